// [hdl/psta_pkg.sv]
package psta_pkg;
	localparam int PSTA_PADDR_W = 24;
	localparam int PSTA_EA_W = 16;
	localparam int PSTA_PAGE_W = 8;
	localparam int PSTA_WORD_W = 24;
	localparam int PSTA_LOW_HI = 15;
	localparam int PSTA_HIGH_LO = 16;
	localparam int PSTA_HIGH_HI = 23;
	localparam int PSTA_VIS_LO_HI = 14;
	localparam int PSTA_VIS_BIT = 15;
	localparam logic [7:0] PSTA_VIS_PROG = 8'h00;
	localparam logic [7:0] PSTA_VIS_EEPROM = 8'hff;
	localparam int PSTA_WRITE_BLOCK = 32;
	localparam int PSTA_BYTES_PER_INSTR = 3;
	localparam int PSTA_ERASE_32 = 32;
	localparam int PSTA_ERASE_64 = 64;
	localparam int PSTA_ERASE_128 = 128;
	localparam logic [1:0] PSTA_NVOP_E32 = 2'h0;
	localparam logic [1:0] PSTA_NVOP_E64 = 2'h1;
	localparam logic [1:0] PSTA_NVOP_E128 = 2'h2;
	localparam logic [1:0] PSTA_NVOP_WRITE = 2'h3;
	localparam logic [7:0] PSTA_RESET_PAGE = 8'h00;
	typedef enum logic [2:0] {
		PSTA_OP_NONE,
		PSTA_OP_FETCH,
		PSTA_OP_READ_LOW,
		PSTA_OP_READ_HIGH,
		PSTA_OP_WRITE_LOW,
		PSTA_OP_WRITE_HIGH,
		PSTA_OP_VIS_READ
	} psta_op_t;
	typedef enum logic {
		PSTA_SEL_PROG,
		PSTA_SEL_EEPROM
	} psta_space_t;
endpackage : psta_pkg

// [hdl/psta_mem_if.sv]
`timescale 1ns/1ps
interface psta_mem_if;
	import psta_pkg::*;
	logic req;
	logic wr;
	logic [PSTA_PADDR_W-1:0] addr;
	logic [PSTA_WORD_W-1:0] wdata;
	logic [2:0] lane_en;
	logic [PSTA_WORD_W-1:0] rdata;
	modport ctl (output req, output wr, output addr, output wdata, output lane_en, input rdata);
	modport mem (input req, input wr, input addr, input wdata, input lane_en, output rdata);
endinterface : psta_mem_if

// [hdl/psta_flash_mem.sv]
`timescale 1ns/1ps
module psta_flash_mem #(
	parameter int DEPTH = 1024
) (
	input wire logic core_clk_in,
	psta_mem_if.mem bus
);
	import psta_pkg::*;
	localparam int AW = $clog2(DEPTH);
	logic [PSTA_WORD_W-1:0] mem_q [DEPTH];
	logic [PSTA_WORD_W-1:0] rdata_r;
	logic [AW-1:0] idx;
	assign idx = bus.addr[AW:1];
	assign bus.rdata = rdata_r;
	always_ff @(posedge core_clk_in) begin
		if (bus.req && bus.wr) begin
			for (int i = 0; i < 3; i++) begin
				if (bus.lane_en[i]) begin
					mem_q[idx][i*8 +: 8] <= bus.wdata[i*8 +: 8];
				end
			end
		end
		rdata_r <= mem_q[idx];
	end
endmodule : psta_flash_mem

// [hdl/psta_access.sv]
`timescale 1ns/1ps
module psta_access #(
	parameter int MEM_DEPTH = 1024
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire psta_pkg::psta_op_t op_in,
	input wire logic byte_mode_in,
	input wire logic [psta_pkg::PSTA_EA_W-1:0] ea_in,
	input wire logic [psta_pkg::PSTA_PADDR_W-1:0] pc_in,
	input wire logic [psta_pkg::PSTA_PAGE_W-1:0] table_page_in,
	input wire logic [psta_pkg::PSTA_PAGE_W-1:0] visibility_page_in,
	input wire logic [15:0] wdata_in,
	input wire logic [1:0] nv_operation_select_in,
	output logic [psta_pkg::PSTA_PADDR_W-1:0] paddr_out,
	output logic [15:0] rdata_out,
	output logic rvalid_out,
	output logic eeprom_sel_out,
	output logic vis_page_err_out,
	output logic [7:0] nv_block_instr_out,
	output logic [8:0] nv_block_bytes_out,
	output logic nv_is_write_out
);
	import psta_pkg::*;
	if (MEM_DEPTH < 2 || MEM_DEPTH > (1 << (PSTA_PADDR_W - 1)) ||
		(MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("MEM_DEPTH must be a power of two that fits the word address");
	end
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [PSTA_PADDR_W-1:0] paddr;
		logic [15:0] rdata;
		logic rvalid;
		logic eeprom_sel;
		logic vis_err;
		logic [7:0] blk_instr;
		logic [8:0] blk_bytes;
		logic nv_write;
		psta_op_t op_d;
		logic byte_d;
		logic ea0_d;
	} psta_state_t;
	psta_state_t st_r;
	psta_state_t st_nxt;
	psta_mem_if mbus();
	function automatic logic [7:0] blk_size(input logic [1:0] sel);
		case (sel)
			PSTA_NVOP_E64: blk_size = 8'(PSTA_ERASE_64);
			PSTA_NVOP_E128: blk_size = 8'(PSTA_ERASE_128);
			PSTA_NVOP_E32: blk_size = 8'(PSTA_ERASE_32);
			default: blk_size = 8'(PSTA_WRITE_BLOCK);
		endcase
	endfunction : blk_size
	// address and lane helpers
	function automatic logic [PSTA_PADDR_W-1:0] tbl_addr(input logic [PSTA_PAGE_W-1:0] pg,
		input logic [PSTA_EA_W-1:0] ea);
		tbl_addr = {pg, ea};
	endfunction : tbl_addr
	function automatic logic [PSTA_PADDR_W-1:0] fetch_addr(input logic [PSTA_PADDR_W-1:0] pc);
		fetch_addr = {1'b0, pc[22:1], 1'b0};
	endfunction : fetch_addr
	function automatic logic [PSTA_PADDR_W-1:0] vis_addr(input logic [PSTA_PAGE_W-1:0] pg,
		input logic [PSTA_EA_W-1:0] ea);
		vis_addr = {1'b0, pg, ea[PSTA_VIS_LO_HI:0]};
	endfunction : vis_addr
	function automatic logic [PSTA_WORD_W-1:0] low_wdata(input logic bm, input logic [15:0] d);
		if (bm) begin
			low_wdata = {8'h00, d[7:0], d[7:0]};
		end else begin
			low_wdata = {8'h00, d};
		end
	endfunction : low_wdata
	function automatic logic [2:0] low_lanes(input logic bm, input logic hi);
		if (!bm) begin
			low_lanes = 3'h3;
		end else begin
			low_lanes = hi ? 3'h2 : 3'h1;
		end
	endfunction : low_lanes
	function automatic logic [15:0] low_pick(input logic [PSTA_WORD_W-1:0] w, input logic bm,
		input logic hi);
		if (!bm) begin
			low_pick = w[PSTA_LOW_HI:0];
		end else if (hi) begin
			low_pick = {8'h00, w[15:8]};
		end else begin
			low_pick = {8'h00, w[7:0]};
		end
	endfunction : low_pick
	function automatic logic [15:0] high_pick(input logic [PSTA_WORD_W-1:0] w, input logic bm,
		input logic hi);
		if (bm && hi) begin
			high_pick = 16'h0000;
		end else begin
			high_pick = {8'h00, w[PSTA_HIGH_HI:PSTA_HIGH_LO]};
		end
	endfunction : high_pick
	////////////////////////////////////////////////////////////////
	// memory request decode
	logic [PSTA_PADDR_W-1:0] addr_c;
	logic [PSTA_WORD_W-1:0] wd_c;
	logic [2:0] lane_c;
	logic req_c;
	logic wr_c;
	always_comb begin
		addr_c = '0;
		wd_c = '0;
		lane_c = 3'h0;
		req_c = 1'b0;
		wr_c = 1'b0;
		case (op_in)
			PSTA_OP_FETCH: begin
				addr_c = fetch_addr(pc_in);
				req_c = 1'b1;
			end
			PSTA_OP_READ_LOW, PSTA_OP_READ_HIGH: begin
				addr_c = tbl_addr(table_page_in, ea_in);
				req_c = 1'b1;
			end
			PSTA_OP_WRITE_LOW: begin
				addr_c = tbl_addr(table_page_in, ea_in);
				req_c = 1'b1;
				wr_c = 1'b1;
				wd_c = low_wdata(byte_mode_in, wdata_in);
				lane_c = low_lanes(byte_mode_in, ea_in[0]);
			end
			PSTA_OP_WRITE_HIGH: begin
				addr_c = tbl_addr(table_page_in, ea_in);
				req_c = 1'b1;
				wr_c = 1'b1;
				wd_c = {wdata_in[7:0], 16'h0000};
				lane_c = (byte_mode_in && ea_in[0]) ? 3'h0 : 3'h4;
			end
			PSTA_OP_VIS_READ: begin
				addr_c = vis_addr(visibility_page_in, ea_in);
				req_c = (visibility_page_in == PSTA_VIS_PROG);
			end
			default: begin
				addr_c = '0;
			end
		endcase
	end
	assign mbus.req = req_c;
	assign mbus.wr = wr_c;
	assign mbus.addr = addr_c;
	assign mbus.wdata = wd_c;
	assign mbus.lane_en = lane_c;
	psta_flash_mem #(
		.DEPTH(MEM_DEPTH)
	) u_mem (
		.core_clk_in(core_clk_in),
		.bus(mbus.mem)
	);
	////////////////////////////////////////////////////////////////
	// registered answers
	always_comb begin
		st_nxt = st_r;
		st_nxt.paddr = addr_c;
		st_nxt.op_d = op_in;
		st_nxt.byte_d = byte_mode_in;
		st_nxt.ea0_d = ea_in[0];
		st_nxt.eeprom_sel = (op_in == PSTA_OP_VIS_READ) &&
			(visibility_page_in == PSTA_VIS_EEPROM);
		st_nxt.vis_err = (op_in == PSTA_OP_VIS_READ) &&
			(visibility_page_in != PSTA_VIS_PROG) &&
			(visibility_page_in != PSTA_VIS_EEPROM);
		st_nxt.blk_instr = blk_size(nv_operation_select_in);
		st_nxt.blk_bytes = 9'(blk_size(nv_operation_select_in) * PSTA_BYTES_PER_INSTR);
		st_nxt.nv_write = (nv_operation_select_in == PSTA_NVOP_WRITE);
		st_nxt.rvalid = 1'b0;
		case (st_r.op_d)
			PSTA_OP_READ_LOW, PSTA_OP_VIS_READ, PSTA_OP_FETCH: begin
				st_nxt.rvalid = 1'b1;
				st_nxt.rdata = low_pick(mbus.rdata, st_r.byte_d, st_r.ea0_d);
			end
			PSTA_OP_READ_HIGH: begin
				st_nxt.rvalid = 1'b1;
				st_nxt.rdata = high_pick(mbus.rdata, st_r.byte_d, st_r.ea0_d);
			end
			default: begin
				st_nxt.rvalid = 1'b0;
			end
		endcase
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '{paddr: '0, rdata: 16'h0000, rvalid: 1'b0, eeprom_sel: 1'b0,
				vis_err: 1'b0, blk_instr: 8'(PSTA_WRITE_BLOCK),
				blk_bytes: 9'(PSTA_WRITE_BLOCK * PSTA_BYTES_PER_INSTR), nv_write: 1'b0,
				op_d: PSTA_OP_NONE, byte_d: 1'b0, ea0_d: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign paddr_out = st_r.paddr;
	assign rdata_out = st_r.rdata;
	assign rvalid_out = st_r.rvalid;
	assign eeprom_sel_out = st_r.eeprom_sel;
	assign vis_page_err_out = st_r.vis_err;
	assign nv_block_instr_out = st_r.blk_instr;
	assign nv_block_bytes_out = st_r.blk_bytes;
	assign nv_is_write_out = st_r.nv_write;
endmodule : psta_access

// [dv/psta_core_model.sv]
`timescale 1ns/1ps
module psta_core_model (
	input logic core_clk_in,
	output psta_pkg::psta_op_t op_out,
	output logic bm_out,
	output logic [15:0] ea_out,
	output logic [23:0] pc_out,
	output logic [7:0] tp_out,
	output logic [7:0] vp_out,
	output logic [15:0] wd_out,
	output logic [1:0] sel_out
);
	import psta_pkg::*;
	initial begin
		op_out = PSTA_OP_NONE;
		{bm_out, ea_out, pc_out, wd_out, vp_out, sel_out} = '0;
		tp_out = 8'h5a;
	end
	// one access per edge, visibility page as commanded, table page fixed at 5a
	task automatic issue(psta_op_t o, logic b, logic [23:0] a, logic [15:0] d, logic [7:0] v,
		logic [1:0] s);
		@(posedge core_clk_in);
		op_out <= o;
		bm_out <= b;
		ea_out <= a[15:0];
		pc_out <= a;
		wd_out <= d;
		vp_out <= v;
		sel_out <= s;
	endtask : issue
endmodule : psta_core_model

// [dv/psta_access_asserts.sv]
`timescale 1ns/1ps
module psta_access_asserts (
	input logic core_clk_in,
	input logic rst_n_in,
	input psta_pkg::psta_op_t op_in,
	input logic [15:0] ea_in,
	input logic [23:0] pc_in,
	input logic [7:0] table_page_in,
	input logic [7:0] visibility_page_in,
	input logic [1:0] nv_operation_select_in,
	input logic [23:0] paddr_out,
	input logic rvalid_out,
	input logic eeprom_sel_out,
	input logic vis_page_err_out,
	input logic [7:0] nv_block_instr_out,
	input logic [8:0] nv_block_bytes_out,
	input logic nv_is_write_out
);
	import psta_pkg::*;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_table_addr: assert property (
		op_in inside {PSTA_OP_READ_LOW, PSTA_OP_READ_HIGH, PSTA_OP_WRITE_LOW, PSTA_OP_WRITE_HIGH}
		|=> paddr_out == {$past(table_page_in), $past(ea_in)}) else $error("table address");
	chk_fetch_addr: assert property (
		op_in == PSTA_OP_FETCH |=> paddr_out == {1'b0, $past(pc_in[22:1]), 1'b0})
		else $error("fetch address");
	chk_vis_addr: assert property (
		op_in == PSTA_OP_VIS_READ
		|=> paddr_out == {1'b0, $past(visibility_page_in), $past(ea_in[14:0])})
		else $error("visibility address");
	chk_vis_eeprom: assert property (
		op_in == PSTA_OP_VIS_READ && visibility_page_in == 8'hff
		|=> eeprom_sel_out && !vis_page_err_out) else $error("eeprom select");
	chk_vis_bad_page: assert property (
		op_in == PSTA_OP_VIS_READ && !(visibility_page_in inside {8'h00, 8'hff})
		|=> vis_page_err_out && !eeprom_sel_out) else $error("bad page flag");
	chk_write_block: assert property (
		nv_operation_select_in == PSTA_NVOP_WRITE |=> nv_is_write_out
		&& nv_block_instr_out == 8'h20 && nv_block_bytes_out == 9'h060) else $error("write block");
	chk_erase_block: assert property (
		nv_operation_select_in != PSTA_NVOP_WRITE |=> !nv_is_write_out
		&& nv_block_instr_out == (8'h20 << $past(nv_operation_select_in))
		&& nv_block_bytes_out == 9'(nv_block_instr_out) * 9'h003) else $error("erase block");
	chk_read_answer: assert property (
		op_in inside {PSTA_OP_READ_LOW, PSTA_OP_READ_HIGH} |-> ##2 rvalid_out)
		else $error("read answer");
endmodule : psta_access_asserts
bind psta_access psta_access_asserts u_chk (.core_clk_in, .rst_n_in, .op_in, .ea_in, .pc_in,
	.table_page_in, .visibility_page_in, .nv_operation_select_in, .paddr_out, .rvalid_out,
	.eeprom_sel_out, .vis_page_err_out, .nv_block_instr_out, .nv_block_bytes_out,
	.nv_is_write_out);

// [dv/psta_access_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module psta_access_tb;
	import psta_pkg::*;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	int errors = 0;
	int n_compared = 0;
	psta_op_t op;
	logic bm, rvalid, ee, verr, isw;
	logic [15:0] ea, wd, rdata;
	logic [23:0] pc, paddr;
	logic [7:0] tp, vp, instr, vpg = 8'h00;
	logic [8:0] bytes;
	logic [1:0] sel, nsel = 2'h0;
	always #25 core_clk_in = ~core_clk_in;
	psta_core_model core (.core_clk_in, .op_out(op), .bm_out(bm), .ea_out(ea), .pc_out(pc),
		.tp_out(tp), .vp_out(vp), .wd_out(wd), .sel_out(sel));
	psta_access DUT (.core_clk_in, .rst_n_in, .op_in(op), .byte_mode_in(bm), .ea_in(ea),
		.pc_in(pc), .table_page_in(tp), .visibility_page_in(vp), .wdata_in(wd),
		.nv_operation_select_in(sel), .paddr_out(paddr), .rdata_out(rdata), .rvalid_out(rvalid),
		.eeprom_sel_out(ee), .vis_page_err_out(verr), .nv_block_instr_out(instr),
		.nv_block_bytes_out(bytes), .nv_is_write_out(isw));
	task automatic go(psta_op_t o, logic b, logic [23:0] a, logic [15:0] d);
		core.issue(o, b, a, d, vpg, nsel);
		core.issue(PSTA_OP_NONE, b, a, d, vpg, nsel);
		#1;
	endtask : go
	task automatic rd(logic [15:0] x);
		@(posedge core_clk_in);
		#1;
		`CHK(rvalid, 1'b1)
		`CHK(rdata, x)
	endtask : rd
	task automatic close_out();
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	////////////////////////////////////////
	task automatic t_low_high();
		go(PSTA_OP_WRITE_LOW, 1'b0, 24'h000010, 16'h1234);
		`CHK(paddr, 24'h5a0010)
		go(PSTA_OP_WRITE_LOW, 1'b1, 24'h000011, 16'h00ab);
		go(PSTA_OP_WRITE_HIGH, 1'b0, 24'h000010, 16'h00c3);
		go(PSTA_OP_READ_LOW, 1'b0, 24'h000010, 16'h0000);
		rd(16'hab34);
		go(PSTA_OP_READ_HIGH, 1'b0, 24'h000010, 16'h0000);
		rd(16'h00c3);
		go(PSTA_OP_READ_HIGH, 1'b1, 24'h000011, 16'h0000);
		rd(16'h0000);
		go(PSTA_OP_FETCH, 1'b0, 24'h800011, 16'h0000);
		`CHK(paddr, 24'h000010)
		rd(16'hab34);
		go(PSTA_OP_READ_LOW, 1'b1, 24'h000011, 16'h0000);
		rd(16'h00ab);
		go(PSTA_OP_WRITE_LOW, 1'b1, 24'h000010, 16'h0077);
		go(PSTA_OP_READ_LOW, 1'b1, 24'h000010, 16'h0000);
		rd(16'h0077);
		go(PSTA_OP_READ_HIGH, 1'b1, 24'h000010, 16'h0000);
		rd(16'h00c3);
		go(PSTA_OP_WRITE_HIGH, 1'b1, 24'h000010, 16'h0055);
		go(PSTA_OP_WRITE_HIGH, 1'b1, 24'h000011, 16'h0099);
		go(PSTA_OP_READ_HIGH, 1'b0, 24'h000010, 16'h0000);
		rd(16'h0055);
	endtask : t_low_high
	task automatic t_vis();
		logic [7:0] pg [3] = '{8'h00, 8'hff, 8'h55};
		foreach (pg[i]) begin
			vpg = pg[i];
			go(PSTA_OP_VIS_READ, 1'b0, 24'h008123, 16'h0000);
			`CHK(paddr, {1'b0, pg[i], 15'h0123})
			`CHK(ee, pg[i] == 8'hff)
			`CHK(verr, pg[i] == 8'h55)
		end
		vpg = 8'h00;
	endtask : t_vis
	task automatic t_nv();
		for (int s = 0; s < 4; s++) begin
			nsel = 2'(s);
			go(PSTA_OP_NONE, 1'b0, 24'h000000, 16'h0000);
			`CHK(instr, (s == 3) ? 8'h20 : 8'(8'h20 << s))
			`CHK(bytes, (s == 3) ? 9'h060 : 9'(9'h060 << s))
			`CHK(isw, s == 3)
		end
	endtask : t_nv
	initial begin
		repeat (12) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		t_low_high();
		t_vis();
		t_nv();
		close_out();
	end
	initial begin
		#200000;
		errors++;
		close_out();
	end
endmodule : psta_access_tb
